// ---- verilog/sram_device.sv ----
// Memory end: samples the link clocks and pins on its own clock, holds the
// array, and returns read bursts with echo strobes.
// Assumes all link pins are held for at least three clocks around each edge.
`timescale 1ns/100ps
`default_nettype none
`include "sram_defines.svh"
module sram_device import sram_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    sram_link.dev link,
    output logic cal_update,
    output logic cal_level,
    output logic pll_bypassed
);
    localparam int PW = 8 + `ADDR_W + `DATA_W + `LANES;
    localparam logic [PW-1:0] PIN_RST = {1'b0, 1'b1, 1'b1, 1'b1, `SEL_IDLE, `SEL_IDLE,
                                         `ADDR_W'(0), `DATA_W'(0), `MASK_IDLE, 1'b0,
                                         `BYPASS_IDLE};
    localparam cal_t CAL_LAST = cal_t'(`CAL_PERIOD_CYC - 1);

    typedef struct packed {
        logic k;
        logic kn;
        logic rp;
        logic rn;
        logic rd_pend;
        addr_t rd_addr;
        logic arm_v;
        addr_t arm_addr;
        out_e out_st;
        addr_t out_addr;
        word_t q;
        logic oe;
        logic strobe_p;
        logic strobe_n;
        logic wr_pend;
        word_t w0;
        mask_t m0;
        cal_t cal_cnt;
        logic cal_upd;
        logic cal_lvl;
        logic bypassed;
    } state_s;
    state_s st_q;
    state_s st_d;

    word_t mem [`MEM_WORDS];
    logic [PW-1:0] pins;
    logic k_s;
    logic kn_s;
    logic c_s;
    logic cn_s;
    logic rs_n_s;
    logic ws_n_s;
    addr_t addr_s;
    word_t data_s;
    mask_t mask_s;
    logic zq_s;
    logic pll_n_s;
    logic single_clk;
    logic ref_p;
    logic ref_n;
    logic k_rise;
    logic kn_rise;
    logic rp_rise;
    logic rn_rise;
    logic mem_we;
    addr_t mem_addr;
    word_t old0;
    word_t old1;
    word_t merged0;
    word_t merged1;

    ////////////////////////////////////////////////////////////////////////
    // Every pin, clocks included, is resynchronised as one bundle so that
    // data and the edges that qualify it keep their relative timing.
    sync2 #(.W(PW), .RST_VAL(PIN_RST)) pin_sync (
        .clk(clk),
        .rst(rst),
        .d({link.k, link.k_n, link.c, link.c_n, link.read_select_n, link.write_select_n,
            link.addr, link.wr_bus_in, link.byte_lane_write_n, link.impedance_tune,
            link.pll_bypass_n}),
        .q(pins)
    );

    assign {k_s, kn_s, c_s, cn_s, rs_n_s, ws_n_s, addr_s, data_s, mask_s, zq_s, pll_n_s} = pins;

    // Output clocks held high select the input pair as return reference.
    assign single_clk = c_s & cn_s;
    assign ref_p = single_clk ? k_s : c_s;
    assign ref_n = single_clk ? kn_s : cn_s;
    assign k_rise = k_s & ~st_q.k;
    assign kn_rise = kn_s & ~st_q.kn;
    assign rp_rise = ref_p & ~st_q.rp;
    assign rn_rise = ref_n & ~st_q.rn;

    ////////////////////////////////////////////////////////////////////////
    // A write burst is committed on K#, when both words and masks are known.
    assign mem_we = kn_rise & st_q.wr_pend;
    assign mem_addr = addr_s;
    assign old0 = mem[{mem_addr, 1'b0}];
    assign old1 = mem[{mem_addr, 1'b1}];

    for (genvar g = 0; g < `LANES; g++) begin : g_lane
        assign merged0[g*`LANE_W +: `LANE_W] = st_q.m0[g] ? old0[g*`LANE_W +: `LANE_W]
                                                          : st_q.w0[g*`LANE_W +: `LANE_W];
        assign merged1[g*`LANE_W +: `LANE_W] = mask_s[g] ? old1[g*`LANE_W +: `LANE_W]
                                                         : data_s[g*`LANE_W +: `LANE_W];
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[{mem_addr, 1'b0}] <= merged0;
            mem[{mem_addr, 1'b1}] <= merged1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.k = k_s;
        st_d.kn = kn_s;
        st_d.rp = ref_p;
        st_d.rn = ref_n;
        st_d.cal_upd = 1'b0;
        st_d.bypassed = ~pll_n_s;
        // Echo strobes copy the reference, so they run with no read and
        // stand still whenever the reference does.
        st_d.strobe_p = ref_p;
        st_d.strobe_n = ref_n;
        if (k_rise) begin
            // A read taken at K(t) is armed at K(t+1) for the next C# rise.
            st_d.arm_v = st_q.rd_pend;
            st_d.arm_addr = st_q.rd_addr;
            // With both selects high, nothing is armed and the address is dropped.
            st_d.rd_pend = ~rs_n_s;
            if (!rs_n_s) begin
                st_d.rd_addr = addr_s;
            end
            // Read and write are decoded independently on the same edge.
            st_d.wr_pend = ~ws_n_s;
            if (!ws_n_s) begin
                st_d.w0 = data_s;
                st_d.m0 = mask_s;
            end
            if (st_q.cal_cnt == CAL_LAST) begin
                st_d.cal_cnt = '0;
                st_d.cal_upd = 1'b1;
                st_d.cal_lvl = zq_s;
            end else begin
                st_d.cal_cnt = st_q.cal_cnt + cal_t'(1);
            end
        end
        if (mem_we) begin
            st_d.wr_pend = 1'b0;
        end
        if (rn_rise) begin
            if (st_q.arm_v) begin
                st_d.q = mem[{st_q.arm_addr, 1'b0}];
                st_d.oe = 1'b1;
                st_d.out_st = OUT_SECOND;
                st_d.out_addr = st_q.arm_addr;
                if (!k_rise) begin
                    st_d.arm_v = 1'b0;
                end
            end else begin
                st_d.oe = 1'b0;
            end
        end
        if (rp_rise) begin
            case (st_q.out_st)
                OUT_SECOND: begin
                    st_d.q = mem[{st_q.out_addr, 1'b1}];
                    st_d.oe = 1'b1;
                    st_d.out_st = OUT_IDLE;
                end
                OUT_IDLE: begin
                    st_d.out_st = OUT_IDLE;
                end
                default: begin
                    st_d.out_st = OUT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{k: 1'b0, kn: 1'b1, rp: 1'b1, rn: 1'b1, rd_pend: 1'b0, rd_addr: '0,
                      arm_v: 1'b0, arm_addr: '0, out_st: OUT_IDLE, out_addr: '0, q: '0,
                      oe: 1'b0, strobe_p: 1'b0, strobe_n: 1'b0, wr_pend: 1'b0, w0: '0,
                      m0: `MASK_IDLE, cal_cnt: '0, cal_upd: 1'b0, cal_lvl: 1'b0,
                      bypassed: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.rd_bus_out = st_q.q;
    assign link.rd_bus_oe = st_q.oe;
    assign link.return_strobe_pos = st_q.strobe_p;
    assign link.return_strobe_neg = st_q.strobe_n;
    assign cal_update = st_q.cal_upd;
    assign cal_level = st_q.cal_lvl;
    assign pll_bypassed = st_q.bypassed;
endmodule
`default_nettype wire

// ---- verilog/sram_defines.svh ----
// Constants shared by both ends of the two-word burst static RAM link.
// Assumes an end clock of 200 MHz; both ends see the link pins only.
//
// Overview of operation
// - read address on K rise, write on K#
// - every transaction is a two-word burst
// - both selects high means no operation
// - write words taken on K then K#
// - data buses are eighteen bits wide
// - read select low on K starts read
// - write select low on K starts write
// - only lanes with low mask are stored
// - two byte lanes for this organization
// - return data follows C pair, else K
// - first word on C# rise, second C
// - unused output clocks are held high
// - echo strobes rise with the return data
// - echo strobes toggle even while data idles
// - echo strobes stop with their reference clock
// - impedance retuned every 1024 input cycles
// - keep the bypass pin high normally
// - read at t returns C#(t+1), C(t+2)
`ifndef SRAM_DEFINES_SVH
`define SRAM_DEFINES_SVH
`define DATA_W 18
`define LANE_W 9
`define LANES 2
`define ADDR_W 20
`define MEM_WORDS (1 << (`ADDR_W + 1))
`define CLK_PERIOD_NS 5
`define K_PERIOD_NS 60
`define K_HALF_CYC (`K_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define K_PRESENT_PH (2 * `K_HALF_CYC - 2)
`define KN_PRESENT_PH (`K_HALF_CYC - 2)
`define PH_W 4
`define CAL_PERIOD_CYC 1024
`define CAL_W 10
`define SEL_IDLE 1'b1
`define MASK_IDLE 2'h3
`define BYPASS_IDLE 1'b1
`endif

// ---- verilog/sram_pkg.sv ----
// Types shared by both ends of the burst static RAM link.
// Assumes the constants header is on the include path.
`include "sram_defines.svh"
package sram_pkg;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`LANES-1:0] mask_t;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`PH_W-1:0] ph_t;
    typedef logic [`CAL_W-1:0] cal_t;
    typedef enum logic {OUT_IDLE, OUT_SECOND} out_e;
    typedef enum logic {CAP_IDLE, CAP_SECOND} cap_e;
endpackage

// ---- verilog/sram_link.sv ----
// Pin bundle between the memory controller and the static RAM.
// Assumes the bench joins both ends on one instance.
`timescale 1ns/100ps
`default_nettype none
interface sram_link;
    import sram_pkg::*;
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic read_select_n;
    logic write_select_n;
    addr_t addr;
    word_t wr_bus_in;
    mask_t byte_lane_write_n;
    word_t rd_bus_out;
    logic rd_bus_oe;
    logic return_strobe_pos;
    logic return_strobe_neg;
    logic impedance_tune;
    logic pll_bypass_n;
    modport dev(
        input k, k_n, c, c_n, read_select_n, write_select_n, addr, wr_bus_in,
        input byte_lane_write_n, impedance_tune, pll_bypass_n,
        output rd_bus_out, rd_bus_oe, return_strobe_pos, return_strobe_neg
    );
    modport ctl(
        output k, k_n, c, c_n, read_select_n, write_select_n, addr, wr_bus_in,
        output byte_lane_write_n, impedance_tune, pll_bypass_n,
        input rd_bus_out, rd_bus_oe, return_strobe_pos, return_strobe_neg
    );
endinterface
`default_nettype wire

// ---- verilog/sync2.sv ----
// Two-flop synchroniser for a bundle of pins from another clock.
// Assumes each bit is sampled on its own; buses must be held stable by the sender.
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } state_s;
    state_s st_q;
    state_s st_d;

    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= {RST_VAL, RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule
`default_nettype wire

// ---- verilog/sram_ctrl.sv ----
// Controller end: makes the K and C clocks by division, issues bursts,
// and gathers returned read words. Assumes one user request per K cycle.
`timescale 1ns/100ps
`default_nettype none
`include "sram_defines.svh"
module sram_ctrl import sram_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    sram_link.ctl link,
    input wire logic use_out_clk,
    input wire logic bypass_req,
    input wire logic zq_level,
    input wire logic rd_req,
    input wire addr_t rd_addr,
    input wire logic wr_req,
    input wire addr_t wr_addr,
    input wire word_t wr_word0,
    input wire word_t wr_word1,
    input wire mask_t wr_mask0,
    input wire mask_t wr_mask1,
    output logic req_take,
    output logic rd_done,
    output word_t rd_word0,
    output word_t rd_word1
);
    localparam ph_t PH_LAST = ph_t'(2 * `K_HALF_CYC - 1);
    localparam ph_t PH_HALF = ph_t'(`K_HALF_CYC);
    localparam ph_t PH_K = ph_t'(`K_PRESENT_PH);
    localparam ph_t PH_KN = ph_t'(`KN_PRESENT_PH);
    localparam int RW = 3 + `DATA_W;

    typedef struct packed {
        ph_t ph;
        logic k;
        logic c;
        logic rs_n;
        logic ws_n;
        addr_t addr;
        word_t data;
        mask_t mask;
        logic wr_now;
        addr_t wr_addr;
        word_t word1;
        mask_t mask1;
        logic pll_n;
        logic zq;
        logic sp;
        logic sn;
        cap_e cap;
        word_t w0;
        word_t w1;
        logic done;
    } state_s;
    state_s st_q;
    state_s st_d;
    logic [RW-1:0] ret_s;

    ////////////////////////////////////////////////////////////////////////
    sync2 #(.W(RW), .RST_VAL('0)) ret_sync (
        .clk(clk),
        .rst(rst),
        .d({link.return_strobe_pos, link.return_strobe_neg, link.rd_bus_oe, link.rd_bus_out}),
        .q(ret_s)
    );

    assign req_take = (st_q.ph == PH_K);

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.ph = (st_q.ph == PH_LAST) ? '0 : st_q.ph + ph_t'(1);
        st_d.k = (st_d.ph < PH_HALF);
        st_d.c = use_out_clk ? st_d.k : 1'b1;
        st_d.pll_n = ~bypass_req;
        st_d.zq = zq_level;
        // Pins change one clock before each K edge and hold a full half period.
        if (st_q.ph == PH_K) begin
            st_d.rs_n = ~rd_req;
            st_d.ws_n = ~wr_req;
            st_d.addr = rd_addr;
            st_d.data = wr_word0;
            st_d.mask = wr_req ? wr_mask0 : `MASK_IDLE;
            st_d.wr_now = wr_req;
            st_d.wr_addr = wr_addr;
            st_d.word1 = wr_word1;
            st_d.mask1 = wr_mask1;
        end
        if (st_q.ph == PH_KN) begin
            st_d.rs_n = `SEL_IDLE;
            st_d.ws_n = `SEL_IDLE;
            if (st_q.wr_now) begin
                st_d.addr = st_q.wr_addr;
                st_d.data = st_q.word1;
                st_d.mask = st_q.mask1;
            end else begin
                st_d.mask = `MASK_IDLE;
            end
        end
        st_d.sp = ret_s[RW-1];
        st_d.sn = ret_s[RW-2];
        if (ret_s[RW-2] && !st_q.sn && ret_s[RW-3]) begin
            st_d.w0 = ret_s[`DATA_W-1:0];
            st_d.cap = CAP_SECOND;
        end
        if (ret_s[RW-1] && !st_q.sp && ret_s[RW-3] && st_q.cap == CAP_SECOND) begin
            st_d.w1 = ret_s[`DATA_W-1:0];
            st_d.cap = CAP_IDLE;
            st_d.done = 1'b1;
        end
    end

    // The phase starts one step before K rises, so the first K pulse after reset is full width.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{ph: PH_LAST, k: 1'b0, c: 1'b1, rs_n: `SEL_IDLE, ws_n: `SEL_IDLE,
                      addr: '0, data: '0, mask: `MASK_IDLE, wr_now: 1'b0, wr_addr: '0,
                      word1: '0, mask1: `MASK_IDLE, pll_n: `BYPASS_IDLE, zq: 1'b0,
                      sp: 1'b0, sn: 1'b0, cap: CAP_IDLE, w0: '0, w1: '0, done: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.k = st_q.k;
    assign link.k_n = ~st_q.k;
    assign link.c = st_q.c;
    assign link.c_n = use_out_clk ? ~st_q.c : 1'b1;
    assign link.read_select_n = st_q.rs_n;
    assign link.write_select_n = st_q.ws_n;
    assign link.addr = st_q.addr;
    assign link.wr_bus_in = st_q.data;
    assign link.byte_lane_write_n = st_q.mask;
    assign link.impedance_tune = st_q.zq;
    assign link.pll_bypass_n = st_q.pll_n;
    assign rd_done = st_q.done;
    assign rd_word0 = st_q.w0;
    assign rd_word1 = st_q.w1;
endmodule
`default_nettype wire

// ---- bench/sram_link_chk.sv ----
// Concurrent checks on the pins between the controller and the memory end.
// Assumes the bench instantiates it beside the link and feeds it every pin except impedance_tune and pll_bypass_n.
`timescale 1ns/100ps
`default_nettype none
module sram_link_chk import sram_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    input wire logic read_select_n,
    input wire logic write_select_n,
    input wire addr_t addr,
    input wire word_t wr_bus_in,
    input wire mask_t byte_lane_write_n,
    input wire word_t rd_bus_out,
    input wire logic rd_bus_oe,
    input wire logic return_strobe_pos,
    input wire logic return_strobe_neg
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Age of the last read taken on a K rise, saturating so that stale reads never qualify.
    logic k_q;
    logic [7:0] rd_age_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            k_q <= 1'b0;
            rd_age_q <= 8'hFF;
        end else begin
            k_q <= k;
            if (k && !k_q && !read_select_n) begin
                rd_age_q <= 8'h00;
            end else if (rd_age_q != 8'hFF) begin
                rd_age_q <= rd_age_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_k_cycle;
        ##6 $fell(k) ##6 $rose(k);
    endsequence
    sequence s_ref_still;
        ($stable(c) && $stable(c_n) && $stable(k))[*4];
    endsequence
    sequence s_first_word;
        ##[0:1] $rose(return_strobe_neg);
    endsequence
    property p_k_period;
        $rose(k) |-> s_k_cycle;
    endproperty
    property p_rd_pins;
        $rose(k) && !read_select_n |-> (!read_select_n && $stable(addr))[*4];
    endproperty
    property p_wr_k;
        $rose(k) && !write_select_n |-> ($stable(wr_bus_in) && $stable(byte_lane_write_n))[*4];
    endproperty
    property p_wr_kn;
        $rose(k_n) |-> (read_select_n && write_select_n && $stable(addr) && $stable(wr_bus_in)
            && $stable(byte_lane_write_n))[*4];
    endproperty
    property p_oe_cause;
        $rose(rd_bus_oe) |-> rd_age_q < 8'h28;
    endproperty
    property p_oe_burst;
        $rose(rd_bus_oe) |-> rd_bus_oe[*8];
    endproperty
    property p_first_neg;
        $rose(rd_bus_oe) |-> s_first_word;
    endproperty
    property p_echo_c;
        $rose(c) |-> ##[1:5] $rose(return_strobe_pos);
    endproperty
    property p_echo_k;
        $rose(k) && c && c_n |-> ##[1:5] $rose(return_strobe_pos);
    endproperty
    property p_echo_still;
        s_ref_still |-> $stable(return_strobe_pos) && $stable(return_strobe_neg);
    endproperty

    a_k_period:
        assert property (p_k_period) else $error("input clock period or duty is wrong");
    a_rd_pins:
        assert property (p_rd_pins) else $error("read address moved around the K rise");
    a_wr_k:
        assert property (p_wr_k) else $error("first write word or mask moved around the K rise");
    a_wr_kn:
        assert property (p_wr_kn) else $error("write address, word or mask moved around the K# rise");
    a_oe_cause:
        assert property (p_oe_cause) else $error("read data driven without a recent read");
    a_oe_burst:
        assert property (p_oe_burst) else $error("read burst shorter than two words");
    a_first_neg:
        assert property (p_first_neg) else $error("first read word not on the negative strobe");
    a_echo_c:
        assert property (p_echo_c) else $error("echo strobe does not follow the output clock");
    a_echo_k:
        assert property (p_echo_k) else $error("echo strobe does not follow the input clock");
    a_echo_still:
        assert property (p_echo_still) else $error("echo strobe moved while its reference clock stood still");
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench: controller and memory ends joined on one link.
// Assumes a 200 MHz end clock; the controller divides it down for the link clocks.
`timescale 1ns/100ps
`default_nettype none
module testbench import sram_pkg::*;;
    logic clk;
    logic rst = 1'b1;
    logic use_out_clk = 1'b1;
    logic bypass_req = 1'b0;
    logic zq_level = 1'b1;
    logic rd_req = 1'b0;
    addr_t rd_addr = '0;
    logic wr_req = 1'b0;
    addr_t wr_addr = '0;
    word_t wr_word0 = '0;
    word_t wr_word1 = '0;
    mask_t wr_mask0 = 2'h3;
    mask_t wr_mask1 = 2'h3;
    logic req_take;
    logic rd_done;
    word_t rd_word0;
    word_t rd_word1;
    logic cal_update;
    logic cal_level;
    logic pll_bypassed;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int cal_last = 0;
    int cal_seen = 0;
    word_t model [int];

    sram_link link();
    sram_ctrl sram_ctrl_inst (.clk(clk), .rst(rst), .link(link.ctl), .use_out_clk(use_out_clk),
        .bypass_req(bypass_req), .zq_level(zq_level), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_word0(wr_word0), .wr_word1(wr_word1), .wr_mask0(wr_mask0),
        .wr_mask1(wr_mask1), .req_take(req_take), .rd_done(rd_done), .rd_word0(rd_word0), .rd_word1(rd_word1));
    sram_device sram_device_inst (.clk(clk), .rst(rst), .link(link.dev), .cal_update(cal_update),
        .cal_level(cal_level), .pll_bypassed(pll_bypassed));
    sram_link_chk link_chk_inst (.clk(clk), .rst(rst), .k(link.k), .k_n(link.k_n), .c(link.c), .c_n(link.c_n),
        .read_select_n(link.read_select_n), .write_select_n(link.write_select_n), .addr(link.addr),
        .wr_bus_in(link.wr_bus_in), .byte_lane_write_n(link.byte_lane_write_n), .rd_bus_out(link.rd_bus_out),
        .rd_bus_oe(link.rd_bus_oe), .return_strobe_pos(link.return_strobe_pos),
        .return_strobe_neg(link.return_strobe_neg));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic compare(input word_t seen, input word_t exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Requests are offered one edge after the previous take, so no signal is assigned twice in a step.
    task automatic issue(input logic rd, input addr_t ra, input logic wr, input addr_t wa,
                         input word_t w0, input word_t w1, input mask_t m0, input mask_t m1);
        int n;
        n = 0;
        @(posedge clk);
        rd_req <= rd;
        rd_addr <= ra;
        wr_req <= wr;
        wr_addr <= wa;
        wr_word0 <= w0;
        wr_word1 <= w1;
        wr_mask0 <= m0;
        wr_mask1 <= m1;
        do begin
            @(posedge clk);
            n++;
        end while (req_take !== 1'b1 && n < 40);
        compare(word_t'(req_take), 18'h00001);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
    endtask

    task automatic note_wr(input addr_t a, input word_t w0, input word_t w1, input mask_t m0, input mask_t m1);
        int b;
        word_t nw [2];
        mask_t m [2];
        b = int'(a) * 2;
        nw[0] = w0;
        nw[1] = w1;
        m[0] = m0;
        m[1] = m1;
        for (int i = 0; i < 2; i++) begin
            if (!model.exists(b + i)) begin
                model[b + i] = '0;
            end
            for (int g = 0; g < 2; g++) begin
                if (!m[i][g]) begin
                    model[b + i][g * 9 +: 9] = nw[i][g * 9 +: 9];
                end
            end
        end
    endtask

    task automatic wait_rd(input addr_t a);
        int n;
        n = 0;
        while (rd_done !== 1'b1 && n < 80) begin
            @(posedge clk);
            n++;
        end
        compare(word_t'(rd_done), 18'h00001);
        compare(rd_word0, model[int'(a) * 2]);
        compare(rd_word1, model[int'(a) * 2 + 1]);
    endtask

    task automatic wr(input addr_t a, input word_t w0, input word_t w1, input mask_t m0, input mask_t m1);
        issue(1'b0, '0, 1'b1, a, w0, w1, m0, m1);
        note_wr(a, w0, w1, m0, m1);
    endtask

    task automatic rd(input addr_t a);
        issue(1'b1, a, 1'b0, '0, '0, '0, 2'h3, 2'h3);
        wait_rd(a);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Calibration pulses are spaced by 1024 link periods of 12 end clocks each.
    always @(posedge clk) begin
        cyc++;
        if (cal_update === 1'b1) begin
            compare(word_t'(cal_level), word_t'(zq_level));
            if (cal_seen > 0) begin
                compare(word_t'(cyc - cal_last), 18'h03000);
            end
            cal_last = cyc;
            cal_seen++;
            zq_level <= 1'b0;
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        compare(word_t'(link.rd_bus_oe), 18'h00000);
        wr(20'h00005, 18'h31234, 18'h2ABCD, 2'h0, 2'h0);
        rd(20'h00005);
        for (int m = 0; m < 4; m++) begin
            wr(addr_t'(20'h00010 + m), 18'h00000, 18'h3FFFF, 2'h0, 2'h0);
            wr(addr_t'(20'h00010 + m), 18'h3FFFF, 18'h00000, mask_t'(m), mask_t'(3 - m));
            rd(addr_t'(20'h00010 + m));
        end
        issue(1'b1, 20'h00005, 1'b1, 20'h00020, 18'h15A5A, 18'h0A5A5, 2'h0, 2'h0);
        note_wr(20'h00020, 18'h15A5A, 18'h0A5A5, 2'h0, 2'h0);
        wait_rd(20'h00005);
        rd(20'h00020);
        repeat (48) @(posedge clk);
        compare(word_t'(link.rd_bus_oe), 18'h00000);
        // Mode changes happen while K is high so that no false output clock edge is made.
        @(posedge clk iff link.k === 1'b1);
        use_out_clk <= 1'b0;
        wr(20'h00030, 18'h2468A, 18'h13579, 2'h0, 2'h0);
        rd(20'h00030);
        @(posedge clk iff link.k === 1'b1);
        use_out_clk <= 1'b1;
        rd(20'h00030);
        bypass_req <= 1'b1;
        repeat (20) @(posedge clk);
        compare(word_t'(pll_bypassed), 18'h00001);
        bypass_req <= 1'b0;
        repeat (20) @(posedge clk);
        compare(word_t'(pll_bypassed), 18'h00000);
        while (cal_seen < 2) begin
            @(posedge clk);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
